// *** tb_top.sv ***
/*
 Testbench for the transceiver host port: registers, queues, half-duplex link.
 Assumes the host model drives the bus; lock and burst pulses come from here.
*/
`timescale 1ns/1ps
module tb_top;
	logic       mclk;
	logic       rst_b;
	logic       sys_reset_n, chip_select_n, write_strobe_n, read_strobe_n;
	logic [3:0] addr;
	logic [7:0] data_in, data_out, tx_sig_word;
	logic       data_oe_n, irq_n, tx_bit, tx_active;
	logic       link_lock, burst_end;
	logic [7:0] rx_sig_word;
	int         miscompares = 0;
	int         checked = 0;

	// Clock
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	thp_host_port uut (.mclk, .rst_b, .sys_reset_n, .chip_select_n, .write_strobe_n,
		.read_strobe_n, .addr, .data_in, .data_out, .data_oe_n, .irq_n, .tx_bit,
		.tx_active, .rx_bit(1'b1), .link_lock, .burst_end,
		.rx_sig_word, .gain_level(8'h40), .tx_sig_word);
	thp_host_model host (.mclk, .data_out, .chip_select_n, .write_strobe_n,
		.read_strobe_n, .sys_reset_n, .addr, .data_in);

	task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] got);
	begin
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	end
	endtask

	task automatic end_of_test;
	begin
		if (miscompares == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask

	// Reset values, read-back, banks and unmapped reads
	task automatic t_regs;
		logic [7:0] r;
	begin
		compare("tx_sig_word", 8'hff, tx_sig_word);
		host.rd(4'h1, r);
		compare("config_high", 8'h80, r);
		host.wr(4'h6, 8'h3c);
		compare("tx_sig_word", 8'h3c, tx_sig_word);
		host.wr(4'h1, 8'hc0);
		host.rd(4'h1, r);
		compare("config_high", 8'hc0, r);
		host.wr(4'h0, 8'h02);
		host.rd(4'h1, r);
		compare("high bank", 8'h00, r);
		host.wr(4'h0, 8'h00);
		host.rd(4'h4, r);
		compare("unmapped", 8'h00, r);
		host.rd(4'h0, r);
		compare("config_low", 8'h00, r);
	end
	endtask

	// Half-duplex send: idle zeros, then one byte LSB first
	task automatic t_half_tx;
		logic [7:0] r;
		logic [7:0] ones;
		int         n;
	begin
		host.wr(4'h1, 8'h60);
		host.pulse_reset();
		// Sending starts at the first bit tick after the self-reset
		repeat (200) @(posedge mclk);
		compare("tx_active", 8'h01, {7'h0, tx_active});
		host.rd(4'h3, r);
		compare("tx pending", 8'h04, r & 8'h04);
		host.wr(4'h3, 8'h04);
		compare("irq_n on", 8'h00, {7'h0, irq_n});
		host.wr(4'h3, 8'h00);
		compare("irq_n off", 8'h01, {7'h0, irq_n});
		ones = 8'h00;
		repeat (1152)
		begin
			@(posedge mclk);
			#1;
			ones = ones + {7'h0, tx_bit};
		end
		compare("idle ones", 8'h00, ones);
		host.wr(4'h2, 8'ha5);
		n = 0;
		while (tx_bit !== 1'b1 && n < 4000)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n == 4000)
		begin
			miscompares++;
			$display("ERROR tx start expected bit seen timeout");
			end_of_test();
		end
		repeat (96) @(posedge mclk);
		#1;
		for (int i = 0; i < 8; i++)
		begin
			r[i] = tx_bit;
			repeat (192) @(posedge mclk);
			#1;
		end
		compare("tx byte", 8'ha5, r);
		compare("tx after byte", 8'h00, {7'h0, tx_bit});
	end
	endtask

	// Direction off: receive zeros, then a flip flushes the queue
	task automatic t_dir_off;
		logic [7:0] r;
	begin
		host.wr(4'h1, 8'he0);
		compare("tx_active off", 8'h00, {7'h0, tx_active});
		repeat (12500) @(posedge mclk);
		host.rd(4'h3, r);
		compare("rx pending", 8'h08, r & 8'h08);
		host.wr(4'h3, 8'h08);
		compare("irq_n rx", 8'h00, {7'h0, irq_n});
		host.wr(4'h3, 8'h00);
		host.rd(4'h2, r);
		compare("rx byte", 8'h00, r);
		host.wr(4'h1, 8'h60);
		repeat (250) @(posedge mclk);
		host.wr(4'h1, 8'he0);
		host.rd(4'h3, r);
		host.rd(4'h3, r);
		compare("rx flushed", 8'h00, r & 8'h08);
	end
	endtask

	// One burst end carrying a received signaling word
	task automatic sig_burst(input logic [7:0] w);
	begin
		@(posedge mclk);
		#1;
		rx_sig_word = w;
		burst_end   = 1'b1;
		@(posedge mclk);
		#1;
		burst_end   = 1'b0;
		rx_sig_word = ~w;
	end
	endtask

	// Full-duplex signaling word capture, interrupt, overwrite, then S/N
	task automatic t_sigw;
		logic [7:0] r;
	begin
		host.wr(4'h1, 8'ha0);
		host.wr(4'h3, 8'h01);
		host.pulse_reset();
		compare("irq_n idle", 8'h01, {7'h0, irq_n});
		@(posedge mclk);
		#1;
		link_lock = 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		compare("tx_sig_word kept", 8'h3c, tx_sig_word);
		sig_burst(8'h5a);
		compare("irq_n sigw", 8'h00, {7'h0, irq_n});
		host.rd(4'h6, r);
		compare("rx_sig_word", 8'h5a, r);
		sig_burst(8'hc3);
		sig_burst(8'h96);
		host.rd(4'h6, r);
		compare("rx_sig overwrite", 8'h96, r);
		host.rd(4'h3, r);
		host.rd(4'h3, r);
		compare("sigw cleared", 8'h00, r & 8'h01);
		compare("irq_n cleared", 8'h01, {7'h0, irq_n});
		repeat (24600) @(posedge mclk);
		host.rd(4'h7, r);
		compare("snr", 8'h40, r);
	end
	endtask

	// Main sequence
	initial
	begin
		link_lock   = 1'b0;
		burst_end   = 1'b0;
		rx_sig_word = 8'h00;
		// Clean falling edge so the asynchronous resets take hold before the first clock
		rst_b = 1'b1;
		#1;
		rst_b = 1'b0;
		repeat (16) @(posedge mclk);
		#1;
		rst_b = 1'b1;
		t_regs();
		t_half_tx();
		t_dir_off();
		t_sigw();
		end_of_test();
	end
endmodule

// *** thp_consts.vh ***
/*
 Constants for the transceiver host port: register addresses, field positions,
 reset values and timing counts. Assumes a 100 MHz master clock.
*/
`ifndef THP_CONSTS_VH
`define THP_CONSTS_VH
// ----------------------------------------
// Register addresses (4-bit)
// ----------------------------------------
`define THP_ADDR_CFG_LOW   4'h0
`define THP_ADDR_CFG_HIGH  4'h1
`define THP_ADDR_QUEUE     4'h2
`define THP_ADDR_IRQ       4'h3
`define THP_ADDR_SIG_WORD  4'h6
`define THP_ADDR_SNR       4'h7
// ----------------------------------------
// Field positions
// ----------------------------------------
`define THP_CL_BANK        1
`define THP_CH_MSEL        0
`define THP_CH_DATA        5
`define THP_CH_HALF        6
`define THP_CH_DIR_N       7
`define THP_IRQ_SIGW       0
`define THP_IRQ_SNR        1
`define THP_IRQ_TXQ        2
`define THP_IRQ_RXQ        3
// ----------------------------------------
// Reset values
// ----------------------------------------
`define THP_CFG_RESET      8'h80
`define THP_SIGW_DEFAULT   8'hff
// ----------------------------------------
// Timing and queue sizes
// ----------------------------------------
`define THP_BIT_DIV        192
`define THP_BIT_DIV_M1     8'hbf
`define THP_SNR_BITS_M1    7'h7f
`define THP_BURST_BITS_M1  9'h11f
`define THP_Q_DEPTH        8
`define THP_Q_LOW_MARK     4'h2
`define THP_Q_HIGH_MARK    4'h6
`endif

// *** thp_fifo.v ***
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module thp_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
)(
	input  wire             mclk,
	input  wire             rst_b,
	input  wire             flush,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready,
	output reg  [AW:0]      level
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	wire            push;
	wire            pop;

	assign in_ready  = (level != DEPTH[AW:0]);
	assign out_valid = (level != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage write
	always @(posedge mclk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// Pointers and fill level
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			level  <= {(AW+1){1'b0}};
		end
		else if (flush)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			level  <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push && !pop)
				level <= level + 1'b1;
			else if (pop && !push)
				level <= level - 1'b1;
		end
	end
endmodule

// *** thp_host_model.sv ***
/*
 Host processor model: register bus cycles and the system reset pulse.
 Assumes the port answers a read within 3 cycles of the strobe falling.
*/
`timescale 1ns/1ps
module thp_host_model (
	input  logic       mclk,
	input  logic [7:0] data_out,
	output logic       chip_select_n,
	output logic       write_strobe_n,
	output logic       read_strobe_n,
	output logic       sys_reset_n,
	output logic [3:0] addr,
	output logic [7:0] data_in
);
	// Idle bus, device selected
	initial
	begin
		chip_select_n  = 1'b0;
		write_strobe_n = 1'b1;
		read_strobe_n  = 1'b1;
		sys_reset_n    = 1'b1;
		addr           = 4'h0;
		data_in        = 8'h00;
	end

	// Write cycle; lines inverted once released
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
	begin
		@(posedge mclk);
		#1;
		addr    = a;
		data_in = d;
		@(posedge mclk);
		#1;
		write_strobe_n = 1'b0;
		repeat (6) @(posedge mclk);
		#1;
		write_strobe_n = 1'b1;
		repeat (6) @(posedge mclk);
		#1;
		addr    = ~a;
		data_in = ~d;
	end
	endtask

	// Read cycle; data taken at the release edge
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
	begin
		@(posedge mclk);
		#1;
		addr = a;
		@(posedge mclk);
		#1;
		read_strobe_n = 1'b0;
		repeat (6) @(posedge mclk);
		d = data_out;
		#1;
		read_strobe_n = 1'b1;
		repeat (6) @(posedge mclk);
		#1;
		addr = ~a;
	end
	endtask

	// System reset pulse after configuration
	task automatic pulse_reset;
	begin
		@(posedge mclk);
		#1;
		sys_reset_n = 1'b0;
		repeat (4) @(posedge mclk);
		#1;
		sys_reset_n = 1'b1;
		repeat (6) @(posedge mclk);
	end
	endtask
endmodule

// *** thp_host_port.v ***
/*
 Host parallel port of a spread-spectrum transceiver, half-duplex data path,
 signaling word and signal-to-noise reporting, interrupt enable and pending.
 Assumes an asynchronous microprocessor bus (strobes synchronised here), a
 serial modem link on the same clock, and gain and burst inputs from logic.
*/
`timescale 1ns/1ps
`include "thp_consts.vh"
module thp_host_port (
	input  wire       mclk,
	input  wire       rst_b,
	input  wire       sys_reset_n,
	input  wire       chip_select_n,
	input  wire       write_strobe_n,
	input  wire       read_strobe_n,
	input  wire [3:0] addr,
	input  wire [7:0] data_in,
	output reg  [7:0] data_out,
	output reg        data_oe_n,
	output reg        irq_n,
	output reg        tx_bit,
	output reg        tx_active,
	input  wire       rx_bit,
	input  wire       link_lock,
	input  wire       burst_end,
	input  wire [7:0] rx_sig_word,
	input  wire [7:0] gain_level,
	output reg  [7:0] tx_sig_word
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	reg [3:0] sync1;
	reg [3:0] sync2;
	reg [7:0] cfg_low;
	reg [7:0] cfg_high;
	reg [3:0] irq_enable;
	reg [3:0] irq_pend;
	reg [7:0] snr_value;
	reg       wr_d;
	reg       rd_d;
	reg       dir_prev;
	reg       sigw_loaded;
	reg       lock_d;
	reg [7:0] rx_sig_hold;
	reg [7:0] bit_div;
	reg [6:0] snr_cnt;
	reg [8:0] burst_cnt;
	reg [2:0] tx_bitpos;
	reg [7:0] tx_shift;
	reg       tx_has;
	reg [2:0] rx_bitpos;
	reg [7:0] rx_shift;
	reg       rx_push;
	reg [7:0] rx_byte;
	reg       rx_s1;
	reg       rx_s2;

	// Strobes and reset pin pass two flip-flops
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync1 <= 4'hf;
			sync2 <= 4'hf;
			rx_s1 <= 1'b0;
			rx_s2 <= 1'b0;
		end
		else
		begin
			sync1 <= {sys_reset_n, chip_select_n, read_strobe_n, write_strobe_n};
			sync2 <= sync1;
			rx_s1 <= rx_bit;
			rx_s2 <= rx_s1;
		end
	end

	wire wr_n_s   = sync2[0];
	wire rd_n_s   = sync2[1];
	wire cs_n_s   = sync2[2];
	wire sreset_n = sync2[3];

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Write taken when the strobe returns high, data then stable
	wire wr_done  = ~wr_d & wr_n_s & ~cs_n_s;
	// Read data taken at strobe fall; pop happens at strobe release
	wire rd_start = rd_d & ~rd_n_s & ~cs_n_s;
	wire rd_done  = ~rd_d & rd_n_s & ~cs_n_s;
	wire low_bank = ~cfg_low[`THP_CL_BANK];
	wire hit_q    = low_bank && (addr == `THP_ADDR_QUEUE);
	wire hit_irq  = low_bank && (addr == `THP_ADDR_IRQ);
	wire data_md  = cfg_high[`THP_CH_DATA];
	wire half_dx  = data_md & cfg_high[`THP_CH_HALF];
	wire dir_en   = ~cfg_high[`THP_CH_DIR_N];
	// Self-reset on direction change in half-duplex or external system reset
	wire dir_flip = half_dx & (dir_en != dir_prev);
	wire path_rst = dir_flip | ~sreset_n;
	wire bit_tick = (bit_div == `THP_BIT_DIV_M1);

	// ----------------------------------------
	// Queues
	// ----------------------------------------
	wire [7:0] txq_data;
	wire       txq_valid;
	wire       txq_in_ready;
	wire [3:0] txq_level;
	wire [7:0] rxq_data;
	wire       rxq_valid;
	wire       rxq_in_ready;
	wire [3:0] rxq_level;
	// Pop in the same tick that loads the shifter, so no byte is dropped unsent
	wire       txq_pop = bit_tick & dir_en & half_dx & (tx_bitpos == 3'h0) & txq_valid;

	thp_fifo #(.WIDTH(8), .DEPTH(`THP_Q_DEPTH), .AW(3)) u_txq (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.flush     (path_rst),
		.in_data   (data_in),
		.in_valid  (wr_done & hit_q),
		.in_ready  (txq_in_ready),
		.out_data  (txq_data),
		.out_valid (txq_valid),
		.out_ready (txq_pop),
		.level     (txq_level)
	);

	thp_fifo #(.WIDTH(8), .DEPTH(`THP_Q_DEPTH), .AW(3)) u_rxq (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.flush     (path_rst),
		.in_data   (rx_byte),
		.in_valid  (rx_push),
		.in_ready  (rxq_in_ready),
		.out_data  (rxq_data),
		.out_valid (rxq_valid),
		.out_ready (rd_done & hit_q),
		.level     (rxq_level)
	);

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// Configuration and enables, undefined until loaded; given a safe value here
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cfg_low    <= 8'h00;
			cfg_high   <= `THP_CFG_RESET;
			irq_enable <= 4'h0;
			wr_d       <= 1'b1;
			rd_d       <= 1'b1;
		end
		else
		begin
			wr_d <= wr_n_s;
			rd_d <= rd_n_s;
			if (wr_done && addr == `THP_ADDR_CFG_LOW)
				cfg_low <= data_in;
			if (wr_done && low_bank && addr == `THP_ADDR_CFG_HIGH)
				cfg_high <= data_in;
			if (wr_done && hit_irq)
				irq_enable <= data_in[3:0];
		end
	end

	// Transmit signaling word; default at first lock if never loaded
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_sig_word <= `THP_SIGW_DEFAULT;
			sigw_loaded <= 1'b0;
			lock_d      <= 1'b0;
		end
		else
		begin
			lock_d <= link_lock;
			if (wr_done && low_bank && addr == `THP_ADDR_SIG_WORD)
			begin
				tx_sig_word <= data_in;
				sigw_loaded <= 1'b1;
			end
			else if (link_lock && !lock_d && !sigw_loaded)
				tx_sig_word <= `THP_SIGW_DEFAULT;
		end
	end

	// ----------------------------------------
	// Link timing and data path
	// ----------------------------------------
	// Bit divider, 128-bit and burst counters
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bit_div   <= 8'h00;
			snr_cnt   <= 7'h00;
			burst_cnt <= 9'h000;
			snr_value <= 8'h00;
			dir_prev  <= 1'b0;
		end
		else if (path_rst)
		begin
			bit_div   <= 8'h00;
			snr_cnt   <= 7'h00;
			burst_cnt <= 9'h000;
			dir_prev  <= dir_en;
		end
		else
		begin
			bit_div <= bit_tick ? 8'h00 : bit_div + 8'h01;
			if (bit_tick)
			begin
				snr_cnt <= snr_cnt + 7'h01;
				if (snr_cnt == `THP_SNR_BITS_M1)
					snr_value <= gain_level;
				if (burst_cnt == `THP_BURST_BITS_M1)
					burst_cnt <= 9'h000;
				else
					burst_cnt <= burst_cnt + 9'h001;
			end
		end
	end

	wire snr_event = bit_tick & (snr_cnt == `THP_SNR_BITS_M1);

	// Serial transmit: raw bytes, zeros when queue empty
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_bitpos <= 3'h0;
			tx_shift  <= 8'h00;
			tx_has    <= 1'b0;
			tx_bit    <= 1'b0;
			tx_active <= 1'b0;
		end
		else if (path_rst || !dir_en || !half_dx)
		begin
			tx_bitpos <= 3'h0;
			tx_has    <= 1'b0;
			tx_bit    <= 1'b0;
			tx_active <= 1'b0;
		end
		else if (bit_tick)
		begin
			tx_active <= 1'b1;
			tx_bitpos <= tx_bitpos + 3'h1;
			if (tx_bitpos == 3'h0)
			begin
				tx_shift <= txq_valid ? txq_data : 8'h00;
				tx_has   <= txq_valid;
				tx_bit   <= txq_valid ? txq_data[0] : 1'b0;
			end
			else
				tx_bit <= tx_has ? tx_shift[tx_bitpos] : 1'b0;
		end
	end

	// Serial receive: bytes assembled with no framing, zeros when idle
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_bitpos <= 3'h0;
			rx_shift  <= 8'h00;
			rx_push   <= 1'b0;
			rx_byte   <= 8'h00;
		end
		else if (path_rst || dir_en || !half_dx)
		begin
			rx_bitpos <= 3'h0;
			rx_push   <= 1'b0;
		end
		else
		begin
			rx_push <= 1'b0;
			if (bit_tick)
			begin
				rx_bitpos <= rx_bitpos + 3'h1;
				// Idle line samples as zero, so zero bytes still arrive
				rx_shift <= {link_lock & rx_s2, rx_shift[7:1]};
				if (rx_bitpos == 3'h7)
				begin
					rx_byte <= {link_lock & rx_s2, rx_shift[7:1]};
					rx_push <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// Signaling word receive and pending bits
	// ----------------------------------------
	wire sigw_event = burst_end & ~half_dx & data_md | burst_end & ~data_md;
	wire irq_rd     = rd_done & hit_irq;
	wire [3:0] pend_set;

	assign pend_set[`THP_IRQ_SIGW] = sigw_event;
	assign pend_set[`THP_IRQ_SNR]  = snr_event;
	assign pend_set[`THP_IRQ_TXQ]  = (txq_level < `THP_Q_LOW_MARK);
	assign pend_set[`THP_IRQ_RXQ]  = (rxq_level > `THP_Q_HIGH_MARK) | ~rxq_in_ready;

	// Pending bits: set wins over clear-on-read
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_sig_hold <= 8'h00;
			irq_pend    <= 4'h0;
			irq_n       <= 1'b1;
		end
		else
		begin
			if (sigw_event)
				rx_sig_hold <= rx_sig_word;
			irq_pend <= (irq_rd ? 4'h0 : irq_pend) | pend_set;
			irq_n    <= ~|(((irq_rd ? 4'h0 : irq_pend) | pend_set) & irq_enable);
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	reg [7:0] next_rdata;
	always @*
	begin
		next_rdata = 8'h00;
		case (addr)
		`THP_ADDR_CFG_LOW:  next_rdata = cfg_low;
		`THP_ADDR_CFG_HIGH: next_rdata = low_bank ? cfg_high : 8'h00;
		`THP_ADDR_QUEUE:    next_rdata = (low_bank & rxq_valid) ? rxq_data : 8'h00;
		`THP_ADDR_IRQ:      next_rdata = low_bank ? {4'h0, irq_pend} : 8'h00;
		`THP_ADDR_SIG_WORD: next_rdata = low_bank ? rx_sig_hold : 8'h00;
		`THP_ADDR_SNR:      next_rdata = low_bank ? snr_value : 8'h00;
		default:            next_rdata = 8'h00;
		endcase
	end

	// Data bus latched at strobe fall, driven while strobe low
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			data_out  <= 8'h00;
			data_oe_n <= 1'b1;
		end
		else
		begin
			if (rd_start)
				data_out <= next_rdata;
			data_oe_n <= rd_n_s | cs_n_s;
		end
	end
endmodule

// *** thp_host_port_asserts.sv ***
/*
 Checker for the transceiver host port: bus turnaround, direction and bit timing.
 Assumes only the port's pins; config and enables are shadowed from bus writes.
*/
`timescale 1ns/1ps
module thp_host_asserts (
	input logic        mclk,
	input logic        rst_b,
	input logic        sys_reset_n,
	input logic        chip_select_n,
	input logic        write_strobe_n,
	input logic        read_strobe_n,
	input logic [3:0]  addr,
	input logic [7:0]  data_in,
	input logic [7:0]  data_out,
	input logic        data_oe_n,
	input logic        irq_n,
	input logic        tx_bit,
	input logic        tx_active,
	input logic [7:0]  tx_sig_word
);
	logic        wr_q;
	logic        bank;
	logic [7:0]  ch;
	logic [3:0]  ie;
	logic        prev_bit;
	logic        armed;
	logic [19:0] gap;

	// Shadow registers, taken at the end of each host write
	always @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			wr_q <= 1'b1;
			bank <= 1'b0;
			ch   <= 8'h80;
			ie   <= 4'h0;
		end
		else
		begin
			wr_q <= write_strobe_n;
			if (!wr_q && write_strobe_n && !chip_select_n)
			begin
				if (addr == 4'h0)
					bank <= data_in[1];
				else if (!bank && addr == 4'h1)
					ch <= data_in;
				else if (!bank && addr == 4'h3)
					ie <= data_in[3:0];
			end
		end

	// Cycles since the last change of the serial line
	always @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			prev_bit <= 1'b0;
			armed    <= 1'b0;
			gap      <= 20'h0;
		end
		else
		begin
			prev_bit <= tx_bit;
			if (!tx_active || !sys_reset_n)
			begin
				armed <= 1'b0;
				gap   <= 20'h0;
			end
			else if (tx_bit != prev_bit)
			begin
				armed <= 1'b1;
				gap   <= 20'h1;
			end
			else
				gap <= gap + 20'h1;
		end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence s_rd_start;
		$fell(read_strobe_n) && !chip_select_n;
	endsequence
	sequence s_dir_on;
		$fell(ch[7]) && ch[6:5] == 2'b11;
	endsequence

	chk_reset_vals: assert property (disable iff (1'b0) !rst_b |-> data_oe_n && irq_n
		&& !tx_active && !tx_bit && tx_sig_word == 8'hff && data_out == 8'h00)
		else $error("outputs not at reset values");
	chk_oe_drive: assert property (s_rd_start |-> ##[1:4] !data_oe_n)
		else $error("read data not driven");
	chk_oe_release: assert property (read_strobe_n [*4] |-> data_oe_n)
		else $error("bus driven without read");
	chk_data_hold: assert property (read_strobe_n [*5] |-> $stable(data_out))
		else $error("read data changed between reads");
	chk_tx_gate: assert property (ch[7] [*6] |-> !tx_active)
		else $error("sending while direction disabled");
	chk_tx_start: assert property (s_dir_on |-> ##[1:240] tx_active)
		else $error("sending did not start");
	chk_bit_period: assert property (armed && tx_active && tx_bit != prev_bit
		|-> gap % 192 == 0)
		else $error("serial bit period wrong");
	chk_irq_quiet: assert property ((ie == 4'h0) [*5] |-> irq_n)
		else $error("interrupt with all enables clear");
endmodule

bind thp_host_port thp_host_asserts u_chk (.mclk, .rst_b, .sys_reset_n, .chip_select_n,
	.write_strobe_n, .read_strobe_n, .addr, .data_in, .data_out, .data_oe_n, .irq_n,
	.tx_bit, .tx_active, .tx_sig_word);
